// File: core/bsp_map.vh
// Summary of operation
// R1: mode select is sampled on each test clock rise and steps the controller.
// R2: mode select, data in and test reset read high when nothing drives them.
// R3: serial data in is captured on the test clock rising edge.
// R4: serial bits go to instruction or selected data register per controller state.
// R5: serial data out changes on the test clock falling edge while shifting.
// R6: serial data out is high impedance whenever no shift is in progress.
// R7: test reset returns controller, instruction register and scan logic to reset; the boundary chain is reset by rstn_i only.
// R8: test logic runs apart from functional clocks, core keeps working meanwhile. Here all test logic is clocked by mclk_i, which samples the test clock.
// R9: four-bit instruction register with the public boundary-scan instructions.
// R10: instructions shift in only in the shift-instruction state.
// R11: current instruction picks the active data register and serial path.
// R12: exactly three data registers: boundary, bypass and identification.
// R13: bypass register is a single flip-flop between data in and data out.
// R14: boundary cells form one serial chain around the core at the pins.
// R15: identification word: version top, part number, maker code, lsb one.
// R16: mandatory boundary-scan behaviour, steered by the external controller.
// R17: standard sixteen-state controller, five high mode samples reach reset.
// R18: after reset the identification instruction is selected.
`ifndef BSP_MAP_VH
`define BSP_MAP_VH

// ---------------------------------------------------------------------
// instruction register
// ---------------------------------------------------------------------
`define BSP_IR_W        4
`define BSP_OP_EXTEST   4'h0
`define BSP_OP_SAMPLE   4'h1
`define BSP_OP_IDCODE   4'h2
`define BSP_OP_BYPASS   4'hf
`define BSP_IR_CAPTURE  4'h1
`define BSP_IR_RESET    `BSP_OP_IDCODE

// ---------------------------------------------------------------------
// identification word layout
// ---------------------------------------------------------------------
`define BSP_ID_W        32
`define BSP_ID_VER_MSB  31
`define BSP_ID_VER_LSB  28
`define BSP_ID_PART_MSB 27
`define BSP_ID_PART_LSB 12
`define BSP_ID_MFR_MSB  11
`define BSP_ID_MFR_LSB  1
`define BSP_ID_FIXED    1'b1
// arbitrary neutral identity values
`define BSP_ID_VER_DEF  4'h1
`define BSP_ID_PART_DEF 16'h1234
`define BSP_ID_MFR_DEF  11'h055

// ---------------------------------------------------------------------
// boundary chain
// ---------------------------------------------------------------------
`define BSP_BND_N       8

`endif

// File: core/bsp_bnd_chain.v
`default_nettype none
`include "bsp_map.vh"

// ---------------------------------------------------------------------
// boundary chain: one capture/shift stage and one update stage per pin
// ---------------------------------------------------------------------
module bsp_bnd_chain #(
   parameter N = `BSP_BND_N
) (
   input  wire         mclk_i,
   input  wire         rstn_i,
   input  wire         capture_i,
   input  wire         shift_i,
   input  wire         update_i,
   input  wire         tdi_i,
   input  wire [N-1:0] pin_i,
   output wire         scan_o,
   output wire [N-1:0] upd_o
);

   reg  [N-1:0] sh_q;
   reg  [N-1:0] upd_q;
   wire [N:0]   link;

   assign link[N] = tdi_i;
   assign scan_o  = link[0];
   assign upd_o   = upd_q;

   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_cell
         assign link[g] = sh_q[g];
         // capture pin level, else shift toward the lsb end of the chain
         always @(posedge mclk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               sh_q[g]  <= 1'b0;
               upd_q[g] <= 1'b0;
            end else begin
               if (capture_i) begin
                  sh_q[g] <= pin_i[g]; // R14
               end else if (shift_i) begin
                  sh_q[g] <= link[g+1]; // R14
               end
               if (update_i) begin
                  upd_q[g] <= sh_q[g];
               end
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// File: core/bsp_tap.v
`default_nettype none
`include "bsp_map.vh"

// ---------------------------------------------------------------------
// boundary-scan test port, oversampling the test clock on mclk_i
// ---------------------------------------------------------------------
module bsp_tap #(
   parameter                      BND_N    = `BSP_BND_N,
   parameter [3:0]                ID_VER   = `BSP_ID_VER_DEF,
   parameter [15:0]               ID_PART  = `BSP_ID_PART_DEF,
   parameter [10:0]               ID_MFR   = `BSP_ID_MFR_DEF
) (
   input  wire             mclk_i,
   input  wire             rstn_i,
   input  wire             tck_i,
   input  wire             tms_i,
   input  wire             tms_float_i,
   input  wire             tdi_i,
   input  wire             tdi_float_i,
   input  wire             trstn_i,
   input  wire             trstn_float_i,
   input  wire [BND_N-1:0] core_out_i,
   input  wire [BND_N-1:0] pin_in_i,
   output reg              tdo_o,
   output reg              tdo_oe_n_o,
   output reg  [BND_N-1:0] pin_out_o
);

   // ------------------------------------------------------------------
   // controller states, one-hot
   // ------------------------------------------------------------------
   localparam [15:0] S_TLR  = 16'h0001;
   localparam [15:0] S_RTI  = 16'h0002;
   localparam [15:0] S_SDR  = 16'h0004;
   localparam [15:0] S_CDR  = 16'h0008;
   localparam [15:0] S_SHDR = 16'h0010;
   localparam [15:0] S_E1DR = 16'h0020;
   localparam [15:0] S_PDR  = 16'h0040;
   localparam [15:0] S_E2DR = 16'h0080;
   localparam [15:0] S_UDR  = 16'h0100;
   localparam [15:0] S_SIR  = 16'h0200;
   localparam [15:0] S_CIR  = 16'h0400;
   localparam [15:0] S_SHIR = 16'h0800;
   localparam [15:0] S_E1IR = 16'h1000;
   localparam [15:0] S_PIR  = 16'h2000;
   localparam [15:0] S_E2IR = 16'h4000;
   localparam [15:0] S_UIR  = 16'h8000;

   localparam [`BSP_ID_W-1:0] ID_WORD = {ID_VER, ID_PART, ID_MFR, `BSP_ID_FIXED};

   // ------------------------------------------------------------------
   // pad pull-ups and pin synchronisers
   // ------------------------------------------------------------------
   // a floating pad reads as high, as the internal pull-up would make it
   wire tms_pad   = tms_float_i   ? 1'b1 : tms_i;   // R2
   wire tdi_pad   = tdi_float_i   ? 1'b1 : tdi_i;   // R2
   wire trstn_pad = trstn_float_i ? 1'b1 : trstn_i; // R2

   reg  tck_s1_q;
   reg  tck_s2_q;
   reg  tck_s3_q;
   reg  tms_s1_q;
   reg  tms_s2_q;
   reg  tdi_s1_q;
   reg  tdi_s2_q;
   reg  trst_s1_q;
   reg  trst_s2_q;

   // all four pins pass the same two stages, so they stay aligned
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tck_s1_q  <= 1'b0;
         tck_s2_q  <= 1'b0;
         tck_s3_q  <= 1'b0;
         tms_s1_q  <= 1'b1;
         tms_s2_q  <= 1'b1;
         tdi_s1_q  <= 1'b1;
         tdi_s2_q  <= 1'b1;
         trst_s1_q <= 1'b0;
         trst_s2_q <= 1'b0;
      end else begin
         tck_s1_q  <= tck_i;
         tck_s2_q  <= tck_s1_q;
         tck_s3_q  <= tck_s2_q;
         tms_s1_q  <= tms_pad;
         tms_s2_q  <= tms_s1_q;
         tdi_s1_q  <= tdi_pad;
         tdi_s2_q  <= tdi_s1_q;
         trst_s1_q <= trstn_pad;
         trst_s2_q <= trst_s1_q;
      end
   end

   // boundary capture reads pin levels only after two stages as well,
   // since the pads change with no relation to mclk_i
   reg  [BND_N-1:0] pin_s1_q;
   reg  [BND_N-1:0] pin_s2_q;

   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_s1_q <= {BND_N{1'b0}};
         pin_s2_q <= {BND_N{1'b0}};
      end else begin
         pin_s1_q <= pin_in_i;
         pin_s2_q <= pin_s1_q; // R14
      end
   end

   // test clock edges seen after the second stage only; the test clock
   // must stay below a quarter of mclk_i or edges get merged
   wire tck_rise = tck_s2_q & ~tck_s3_q; // R8
   wire tck_fall = ~tck_s2_q & tck_s3_q; // R8
   wire trst_act = ~trst_s2_q;

   // ------------------------------------------------------------------
   // controller next state
   // ------------------------------------------------------------------
   reg [15:0] state_q;
   reg [15:0] state_d;

   always @* begin
      state_d = S_TLR;
      case (state_q) // R17
         S_TLR:   state_d = tms_s2_q ? S_TLR  : S_RTI;
         S_RTI:   state_d = tms_s2_q ? S_SDR  : S_RTI;
         S_SDR:   state_d = tms_s2_q ? S_SIR  : S_CDR;
         S_CDR:   state_d = tms_s2_q ? S_E1DR : S_SHDR;
         S_SHDR:  state_d = tms_s2_q ? S_E1DR : S_SHDR;
         S_E1DR:  state_d = tms_s2_q ? S_UDR  : S_PDR;
         S_PDR:   state_d = tms_s2_q ? S_E2DR : S_PDR;
         S_E2DR:  state_d = tms_s2_q ? S_UDR  : S_SHDR;
         S_UDR:   state_d = tms_s2_q ? S_SDR  : S_RTI;
         S_SIR:   state_d = tms_s2_q ? S_TLR  : S_CIR;
         S_CIR:   state_d = tms_s2_q ? S_E1IR : S_SHIR;
         S_SHIR:  state_d = tms_s2_q ? S_E1IR : S_SHIR;
         S_E1IR:  state_d = tms_s2_q ? S_UIR  : S_PIR;
         S_PIR:   state_d = tms_s2_q ? S_E2IR : S_PIR;
         S_E2IR:  state_d = tms_s2_q ? S_UIR  : S_SHIR;
         S_UIR:   state_d = tms_s2_q ? S_SDR  : S_RTI;
         default: state_d = S_TLR; // illegal codes fall back to reset
      endcase
   end

   // mode select taken only on a test clock rise
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= S_TLR;
      end else if (trst_act) begin
         state_q <= S_TLR; // R7
      end else if (tck_rise) begin
         state_q <= state_d; // R1
      end
   end

   // ------------------------------------------------------------------
   // instruction register
   // ------------------------------------------------------------------
   reg [`BSP_IR_W-1:0] ir_sh_q;
   reg [`BSP_IR_W-1:0] ir_q;

   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ir_sh_q <= `BSP_IR_CAPTURE;
         ir_q    <= `BSP_IR_RESET;
      end else if (trst_act || state_q == S_TLR) begin
         ir_sh_q <= `BSP_IR_CAPTURE;
         ir_q    <= `BSP_IR_RESET; // R7 R18
      end else begin
         if (tck_rise && state_q == S_CIR) begin
            ir_sh_q <= `BSP_IR_CAPTURE;
         end else if (tck_rise && state_q == S_SHIR) begin
            ir_sh_q <= {tdi_s2_q, ir_sh_q[`BSP_IR_W-1:1]}; // R3 R9 R10
         end
         // new instruction only takes effect on the falling edge in update
         if (tck_fall && state_q == S_UIR) begin
            ir_q <= ir_sh_q; // R9
         end
      end
   end

   // ------------------------------------------------------------------
   // instruction decode
   // ------------------------------------------------------------------
   reg sel_bnd;
   reg sel_id;
   reg sel_byp;
   reg extest;

   // unknown codes fall to bypass so that a chain never breaks
   always @* begin
      sel_bnd = 1'b0;
      sel_id  = 1'b0;
      sel_byp = 1'b0;
      extest  = 1'b0;
      case (ir_q)
         `BSP_OP_EXTEST: begin
            sel_bnd = 1'b1; // R11
            extest  = 1'b1;
         end
         `BSP_OP_SAMPLE: begin
            sel_bnd = 1'b1; // R11
         end
         `BSP_OP_IDCODE: begin
            sel_id = 1'b1; // R11
         end
         default: begin
            sel_byp = 1'b1; // R11 R12
         end
      endcase
   end

   wire dr_capture = tck_rise && state_q == S_CDR;
   wire dr_shift   = tck_rise && state_q == S_SHDR;
   wire dr_update  = tck_fall && state_q == S_UDR;

   // ------------------------------------------------------------------
   // bypass and identification registers
   // ------------------------------------------------------------------
   reg                 byp_q;
   reg [`BSP_ID_W-1:0] id_sh_q;

   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         byp_q   <= 1'b0;
         id_sh_q <= ID_WORD;
      end else if (trst_act) begin
         byp_q   <= 1'b0;
         id_sh_q <= ID_WORD;
      end else begin
         if (sel_byp && dr_capture) begin
            byp_q <= 1'b0;
         end else if (sel_byp && dr_shift) begin
            byp_q <= tdi_s2_q; // R3 R4 R13
         end
         if (sel_id && dr_capture) begin
            id_sh_q <= ID_WORD; // R15
         end else if (sel_id && dr_shift) begin
            id_sh_q <= {tdi_s2_q, id_sh_q[`BSP_ID_W-1:1]}; // R3 R4
         end
      end
   end

   // ------------------------------------------------------------------
   // boundary chain
   // ------------------------------------------------------------------
   wire             bnd_so;
   wire [BND_N-1:0] bnd_upd;

   bsp_bnd_chain #(
      .N         (BND_N)
   ) u_bnd (
      .mclk_i    (mclk_i),
      .rstn_i    (rstn_i),
      .capture_i (sel_bnd & dr_capture),
      .shift_i   (sel_bnd & dr_shift),
      .update_i  (sel_bnd & dr_update),
      .tdi_i     (tdi_s2_q),
      .pin_i     (pin_s2_q),
      .scan_o    (bnd_so),
      .upd_o     (bnd_upd)
   );

   // ------------------------------------------------------------------
   // serial output and pin drive
   // ------------------------------------------------------------------
   reg dr_so;

   always @* begin
      dr_so = byp_q;
      if (sel_bnd) begin
         dr_so = bnd_so; // R11
      end else if (sel_id) begin
         dr_so = id_sh_q[0]; // R11
      end
   end

   // state after the rise decides; output moves only on the fall or on test reset
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tdo_o      <= 1'b0;
         tdo_oe_n_o <= 1'b1;
      end else if (trst_act) begin
         tdo_o      <= 1'b0;
         tdo_oe_n_o <= 1'b1; // R6 R7
      end else if (tck_fall) begin
         if (state_q == S_SHIR) begin
            tdo_o      <= ir_sh_q[0]; // R5
            tdo_oe_n_o <= 1'b0;
         end else if (state_q == S_SHDR) begin
            tdo_o      <= dr_so; // R5
            tdo_oe_n_o <= 1'b0;
         end else begin
            tdo_oe_n_o <= 1'b1; // R6
         end
      end
   end

   // core keeps its pins unless external test takes them over
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_out_o <= {BND_N{1'b0}};
      end else begin
         pin_out_o <= extest ? bnd_upd : core_out_i; // R8 R16
      end
   end

endmodule

`default_nettype wire

// File: tb/bsp_tap_chk.sv
`default_nettype none
// ---------------------------------------------------------------------
// port checker, sees only bsp_tap ports, including core and pin drive, no internal state
// ---------------------------------------------------------------------
module bsp_tap_chk #(
   parameter BND_N = 8
) (
   input wire logic             mclk_i,
   input wire logic             rstn_i,
   input wire logic             tck_i,
   input wire logic             tms_i,
   input wire logic             tms_float_i,
   input wire logic             trstn_i,
   input wire logic             trstn_float_i,
   input wire logic [BND_N-1:0] core_out_i,
   input wire logic             tdo_o,
   input wire logic             tdo_oe_n_o,
   input wire logic [BND_N-1:0] pin_out_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       tck_q;
   logic       rtms_q;
   logic       ltms_q;
   logic [3:0] sfall_q;
   logic [3:0] trc_q;
   wire        tms_e  = tms_i | tms_float_i;
   wire        trst_e = trstn_i | trstn_float_i;
   // cycles since tck fell, tms of the rise before it, cycles since trst high
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tck_q <= 1'b0;
         rtms_q <= 1'b1;
         ltms_q <= 1'b1;
         sfall_q <= 4'hf;
         trc_q <= 4'h0;
      end else begin
         tck_q <= tck_i;
         if (tck_i && !tck_q) rtms_q <= tms_e;
         if (!tck_i && tck_q) ltms_q <= rtms_q;
         if (!tck_i && tck_q) sfall_q <= 4'h0;
         else if (sfall_q != 4'hf) sfall_q <= sfall_q + 4'h1;
         if (!trst_e) trc_q <= 4'h0;
         else if (trc_q != 4'hf) trc_q <= trc_q + 4'h1;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   // data out and its enable may only move a few cycles after a tck fall (sync delay)
   chk_tdo_after_fall: assert property (
      $changed(tdo_o) && trc_q == 4'hf |-> sfall_q inside {[1:4]})
      else $error("data out moved away from a tck fall");
   chk_oe_after_fall: assert property (
      $changed(tdo_oe_n_o) && trc_q == 4'hf |-> sfall_q inside {[1:4]})
      else $error("enable moved away from a tck fall");
   chk_exit_release: assert property (
      sfall_q == 4'h6 && ltms_q |-> tdo_oe_n_o)
      else $error("driver still on after a high mode rise");
   chk_enter_shift: assert property (
      $fell(tdo_oe_n_o) |-> !ltms_q)
      else $error("driver on without a low mode rise");
   chk_trst_quiet: assert property (
      !trst_e [*4] |=> tdo_oe_n_o && !tdo_o)
      else $error("test reset left the driver on");
   chk_tdo_hold_high: assert property (
      tck_i && $past(tck_i) && $past(tck_i, 2) && trc_q == 4'hf
      |-> $stable(tdo_o) && $stable(tdo_oe_n_o))
      else $error("output changed while tck high");
   chk_rst_release: assert property (
      $rose(rstn_i) |-> tdo_oe_n_o && !tdo_o && pin_out_o == '0)
      else $error("outputs not at reset values");
   chk_pin_cause: assert property (
      $changed(pin_out_o) |-> pin_out_o == $past(core_out_i) || sfall_q inside {[1:4]})
      else $error("pin drive changed without cause");
   cover property ($fell(tdo_oe_n_o));
   cover property (!trst_e [*4]);
   cover property ($changed(pin_out_o) && sfall_q inside {[1:4]});
endmodule
bind bsp_tap bsp_tap_chk #(.BND_N(BND_N)) chk_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
   .tck_i(tck_i), .tms_i(tms_i), .tms_float_i(tms_float_i), .trstn_i(trstn_i),
   .trstn_float_i(trstn_float_i), .core_out_i(core_out_i), .tdo_o(tdo_o),
   .tdo_oe_n_o(tdo_oe_n_o), .pin_out_o(pin_out_o));
`default_nettype wire

// File: tb/bsp_ctl_model.sv
`default_nettype none
// ---------------------------------------------------------------------
// external test controller; tck stands low between steps
// ---------------------------------------------------------------------
module bsp_ctl_model (
   input  wire logic tdo_i,
   input  wire logic tdo_oe_n_i,
   output var logic  tck_o,
   output var logic  tms_o,
   output var logic  tms_float_o,
   output var logic  tdi_o,
   output var logic  tdi_float_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tms_float_o = 1'b0;
      tdi_o = 1'b0;
      tdi_float_o = 1'b0;
   end
   // one 800 ns period entered at an mclk fall; result of the last fall read
   // 400 ns after it, since the port needs a few mclk to resync
   task step(input logic tms, input logic tmsf, input logic tdi, input logic tdif,
             output logic tdo, output logic oe_n);
      tms_o = tms;
      tms_float_o = tmsf;
      tdi_o = tdi;
      tdi_float_o = tdif;
      #200;
      // a released data out line has no pull-up, so it reads as the inverse
      tdo = tdo_oe_n_i ? ~tdo_i : tdo_i;
      oe_n = tdo_oe_n_i;
      tck_o = 1'b1;
      #400;
      tck_o = 1'b0;
      tdi_o = ~tdi; // released data line no longer shows its value
      #200;
   endtask
endmodule
`default_nettype wire

// File: tb/bsp_tap_test.sv
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s: expected %h seen %h", n, e, g); end end
module bsp_tap_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam             BND_N = 8;
   localparam logic [3:0]  VER   = 4'h6;     // arbitrary
   localparam logic [15:0] PART  = 16'h2b5c; // arbitrary
   localparam logic [10:0] MFR   = 11'h3a1;  // arbitrary
   localparam logic [31:0] ID    = {VER, PART, MFR, 1'b1};
   logic             mclk_i = 1'b0;
   logic             rstn_i = 1'b0;
   logic             trstn_i = 1'b1;
   logic             trstn_float_i = 1'b0;
   logic [BND_N-1:0] core_out_i = '0;
   logic [BND_N-1:0] pin_in_i = '0;
   wire logic        tck, tms, tmsf, tdi, tdif, tdo, oe_n;
   wire logic [BND_N-1:0] pin_out;
   integer           num_errors = 0;
   integer           total_checks = 0;
   integer           seed = 32'h9df6fff4;
   logic             tq, oq;
   logic [63:0]      din, fl, d;
   logic [31:0]      capv;
   logic             q[$];
   int               op, i, len;
   always #50 mclk_i = ~mclk_i;
   bsp_tap #(.BND_N(BND_N), .ID_VER(VER), .ID_PART(PART), .ID_MFR(MFR)) dut_u (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .tck_i(tck), .tms_i(tms), .tms_float_i(tmsf),
      .tdi_i(tdi), .tdi_float_i(tdif), .trstn_i(trstn_i), .trstn_float_i(trstn_float_i),
      .core_out_i(core_out_i), .pin_in_i(pin_in_i), .tdo_o(tdo), .tdo_oe_n_o(oe_n),
      .pin_out_o(pin_out));
   bsp_ctl_model ctl_u (.tdo_i(tdo), .tdo_oe_n_i(oe_n), .tck_o(tck), .tms_o(tms),
      .tms_float_o(tmsf), .tdi_o(tdi), .tdi_float_o(tdif));
   task print_verdict;
      if (num_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one scan from idle back to idle, lsb first; ir selects the register path
   task scan(input bit ir, input int n, input logic [63:0] din_l, input logic [63:0] fl_l,
             output logic [63:0] dout);
      int k;
      dout = '0;
      ctl_u.step(1, 0, 0, 0, tq, oq);
      if (ir) ctl_u.step(1, 0, 0, 0, tq, oq);
      ctl_u.step(0, 0, 0, 0, tq, oq);
      ctl_u.step(0, 0, 0, 0, tq, oq);
      for (k = 0; k < n; k++) begin
         ctl_u.step(k == n - 1, 0, din_l[k], fl_l[k], tq, oq);
         dout[k] = tq;
         `CHK("drive enable", 1'b0, oq)
      end
      ctl_u.step(1, 0, 0, 0, tq, oq);
      `CHK("release", 1'b1, oq)
      ctl_u.step(0, 0, 0, 0, tq, oq);
   endtask
   // a hang counts as a failure
   initial begin
      #3000000;
      num_errors++;
      print_verdict;
   end
   initial begin
      repeat (16) @(negedge mclk_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      ctl_u.step(0, 0, 0, 0, tq, oq);
      scan(0, 32, 64'h0, 64'h0, d);
      `CHK("reset id", ID, d[31:0])
      // every opcode: capture word, then the tdi bits after the path length
      for (op = 0; op < 16; op++) begin
         core_out_i = BND_N'($random(seed));
         pin_in_i = BND_N'($random(seed));
         scan(1, 4, 64'(op), 64'h0, d);
         `CHK("ir capture", 4'h1, d[3:0])
         len = (op == 2) ? 32 : (op < 2) ? BND_N : 1;
         capv = (op == 2) ? ID : (op < 2) ? 32'(pin_in_i) : 32'h0;
         din = {$random(seed), $random(seed)};
         fl = (op == 15) ? {$random(seed), $random(seed)} : 64'h0;
         q = {};
         for (i = 0; i < len; i++) q.push_back(capv[i]);
         for (i = 0; i < 48; i++) q.push_back(din[i] | fl[i]);
         scan(0, 48, din, fl, d);
         for (i = 0; i < 48; i++) `CHK("dr bit", q[i], d[i])
         if (op == 0) `CHK("extest pins", din[48-BND_N +: BND_N], pin_out)
         else `CHK("core pins", core_out_i, pin_out)
      end
      // test reset in mid-shift with tck still
      ctl_u.step(1, 0, 0, 0, tq, oq);
      ctl_u.step(0, 0, 0, 0, tq, oq);
      ctl_u.step(0, 0, 0, 0, tq, oq);
      ctl_u.step(0, 0, 1, 0, tq, oq);
      trstn_i = 1'b0;
      repeat (6) @(negedge mclk_i);
      `CHK("trst enable", 1'b1, oe_n)
      `CHK("trst data", 1'b0, tdo)
      trstn_i = 1'b1;
      repeat (6) @(negedge mclk_i);
      ctl_u.step(0, 0, 0, 0, tq, oq);
      scan(0, 32, 64'h0, 64'h0, d);
      `CHK("trst id", ID, d[31:0])
      // undriven trst reads high; undriven tms walks to reset
      trstn_i = 1'b0;
      trstn_float_i = 1'b1;
      scan(1, 4, 64'hf, 64'h0, d);
      scan(0, 2, 64'h3, 64'h0, d);
      `CHK("bypass", 2'b10, d[1:0])
      ctl_u.step(1, 0, 0, 0, tq, oq);
      ctl_u.step(0, 0, 0, 0, tq, oq);
      ctl_u.step(0, 0, 0, 0, tq, oq);
      repeat (5) ctl_u.step(0, 1, 0, 0, tq, oq);
      ctl_u.step(0, 0, 0, 0, tq, oq);
      scan(0, 32, 64'h0, 64'h0, d);
      `CHK("float id", ID, d[31:0])
      print_verdict;
   end
endmodule
`undef CHK
`default_nettype wire
